// File: hdl/pscb_pkg.sv
// Constants, types and register map of the PCI sideband control block
package pscb_pkg;

  // ************************************************************
  // Register map (byte offsets on APB)
  // ************************************************************
  localparam logic [7:0] PSCB_ADDR_CTRL     = 8'h00;
  localparam logic [7:0] PSCB_ADDR_STAT_MSK = 8'h04;
  localparam logic [7:0] PSCB_ADDR_STATE    = 8'h08;
  localparam logic [7:0] PSCB_ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] PSCB_ADDR_IRQ_EN   = 8'h10;
  localparam logic [7:0] PSCB_ADDR_IRQ_CLR  = 8'h14;

  // ************************************************************
  // Field positions
  // ************************************************************
  // Control register
  localparam int PSCB_CTRL_FIFO_A_EN = 0;
  localparam int PSCB_CTRL_FIFO_B_EN = 1;
  localparam int PSCB_CTRL_DUAL_PORT = 2;
  localparam int PSCB_CTRL_RD_EN     = 3;
  localparam int PSCB_CTRL_W         = 4;

  // Device status bits, in shift order
  localparam int PSCB_ST_DET_PERR  = 0;
  localparam int PSCB_ST_SIG_SERR  = 1;
  localparam int PSCB_ST_RCV_MABT  = 2;
  localparam int PSCB_ST_RCV_TABT  = 3;
  localparam int PSCB_ST_SIG_TABT  = 4;
  localparam int PSCB_ST_MDPERR    = 5;
  localparam int PSCB_ST_W         = 6;
  localparam logic [2:0] PSCB_ST_LAST = 3'h5;

  // Fabric and bus pin inputs, as a vector through the synchroniser
  localparam int PSCB_PIN_RD_HOLD    = 0;
  localparam int PSCB_PIN_BURST_N    = 1;
  localparam int PSCB_PIN_INTA_N     = 2;
  localparam int PSCB_PIN_SERR       = 3;
  localparam int PSCB_PIN_SHIFT_EN_N = 4;
  localparam int PSCB_PIN_BUS_RST_N  = 5;
  localparam int PSCB_PIN_W          = 6;

  // Interrupt status bits
  localparam int PSCB_IRQ_DISC    = 0;
  localparam int PSCB_IRQ_WAITOUT = 1;
  localparam int PSCB_IRQ_SERR    = 2;
  localparam int PSCB_IRQ_INTA    = 3;
  localparam int PSCB_IRQ_BUSRST  = 4;
  localparam int PSCB_IRQ_W       = 5;

  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [PSCB_CTRL_W-1:0] PSCB_CTRL_RST    = 4'h8;
  localparam logic [PSCB_ST_W-1:0]   PSCB_STMSK_RST   = 6'h3F;
  localparam logic [PSCB_IRQ_W-1:0]  PSCB_IRQ_RST     = 5'h00;
  localparam logic [PSCB_PIN_W-1:0]  PSCB_PIN_RST     = 6'h36;
  localparam logic [3:0]             PSCB_WAIT_MAX    = 4'h8;
  localparam logic [3:0]             PSCB_WAIT_LAST   = 4'h7;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    PSCB_RD_IDLE,
    PSCB_RD_HOLD,
    PSCB_RD_DATA,
    PSCB_RD_WAIT,
    PSCB_RD_DISC
  } pscb_rd_state_t;

endpackage

// File: hdl/pscb_stat_if.sv
// Interface between the control top and the status output shifter
`timescale 1ns/1ps
`default_nettype none
interface pscb_stat_if;
  import pscb_pkg::*;
  logic [PSCB_ST_W-1:0] status;
  logic [PSCB_ST_W-1:0] mask;
  logic                 shift_en_n;
  logic                 stat_out;
  modport ctrl    (output status, output mask, output shift_en_n,
                   input stat_out);
  modport shifter (input status, input mask, input shift_en_n,
                   output stat_out);
endinterface
`default_nettype wire

// File: hdl/pscb_stat_shift.sv
// Device status output: masked OR or bit-serial shift
`timescale 1ns/1ps
`default_nettype none
module pscb_stat_shift
  import pscb_pkg::*;
(
  // Clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Status path
  pscb_stat_if.shifter st
);

  typedef struct packed {
    logic [2:0] idx;
    logic       out;
  } pscb_shift_st_t;

  pscb_shift_st_t s_reg;
  pscb_shift_st_t s_next;

  always_comb begin
    s_next = s_reg;
    if (st.shift_en_n) begin
      // OR mode holds the shift pointer at its first bit
      s_next.out = |(st.status & st.mask);
      s_next.idx = 3'h0;
    end else begin
      s_next.out = st.status[s_reg.idx];
      if (s_reg.idx == PSCB_ST_LAST) begin
        s_next.idx = 3'h0;
      end else begin
        s_next.idx = s_reg.idx + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign st.stat_out = s_reg.out;

endmodule
`default_nettype wire

// File: hdl/pscb_top.sv
// PCI core sideband control: read hold, bursts, interrupts, status
// Behaviour
// - Read start hold postpones first target read data until released or FIFO full
// - Burst pending active allows up to eight wait states before disconnect
// - Burst pending inactive disconnects at once when read FIFO empties
// - Fabric interrupt request forwarded to INTA#, held two clocks by fabric
// - Fabric system error forwarded to SERR#, held two clocks by fabric
// - Buffered bus clock is given to the fabric for sideband signals
// - Bus reset output to fabric is active while bus reset is received
// - Status shift enable selects how device status reaches the status output
// - Shift enable high gives masked OR of status, shifter held reset
// - Shift enable low gives one status bit per rising clock edge
// - Reported set: parity, system error, aborts, master data parity
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pscb_top
  import pscb_pkg::*;
(
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic [31:0]               prdata,
  output logic                      irq,
  // PCI bus side
  input  wire logic                 pci_rst_n,
  output logic                      inta_n,
  output logic                      serr_n,
  // Target read engine of the core
  input  wire logic                 rd_req,
  input  wire logic                 rd_fifo_full,
  input  wire logic                 rd_fifo_empty,
  output logic                      trdy_n,
  output logic                      stop_n,
  // Device status register of the core
  input  wire logic [PSCB_ST_W-1:0] dev_status,
  // Fabric sideband pins
  input  wire logic                 read_start_hold,
  input  wire logic                 read_burst_pend_n,
  input  wire logic                 fabric_inta_n,
  input  wire logic                 fabric_serr,
  input  wire logic                 status_shift_en_n,
  output logic                      fabric_bus_clk,
  output logic                      fabric_bus_rst_n,
  output logic                      status_out,
  output logic                      fifo_clock_a_en,
  output logic                      fifo_clock_b_en
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [PSCB_PIN_W-1:0]  sync1;
    logic [PSCB_PIN_W-1:0]  sync2;
    logic [PSCB_PIN_W-1:0]  prev;
    pscb_rd_state_t         rd_state;
    logic [3:0]             wait_cnt;
    logic [PSCB_CTRL_W-1:0] ctrl;
    logic [PSCB_ST_W-1:0]   st_mask;
    logic [PSCB_IRQ_W-1:0]  irq_stat;
    logic [PSCB_IRQ_W-1:0]  irq_en;
    logic [31:0]            rdata;
    logic                   inta_n;
    logic                   serr_n;
    logic                   bus_rst_n;
  } pscb_top_st_t;

  pscb_top_st_t s_reg;
  pscb_top_st_t s_next;

  logic [PSCB_IRQ_W-1:0] ev;
  logic                  hold_s;
  logic                  burst_s;
  logic                  wr_acc;
  logic                  rd_setup;

  pscb_stat_if stat_bus ();

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == PSCB_ADDR_CTRL)     || (a == PSCB_ADDR_STAT_MSK) ||
               (a == PSCB_ADDR_STATE)    || (a == PSCB_ADDR_IRQ_STAT) ||
               (a == PSCB_ADDR_IRQ_EN)   || (a == PSCB_ADDR_IRQ_CLR);
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input pscb_top_st_t s);
    read_word = 32'h0000_0000;
    case (a)
      PSCB_ADDR_CTRL:     read_word[PSCB_CTRL_W-1:0] = s.ctrl;
      PSCB_ADDR_STAT_MSK: read_word[PSCB_ST_W-1:0]   = s.st_mask;
      PSCB_ADDR_STATE: begin
        read_word[PSCB_ST_W-1:0] = dev_status;
        read_word[13:8]          = s.sync2;
        read_word[19:16]         = s.wait_cnt;
        read_word[26:24]         = s.rd_state;
      end
      PSCB_ADDR_IRQ_STAT: read_word[PSCB_IRQ_W-1:0] = s.irq_stat;
      PSCB_ADDR_IRQ_EN:   read_word[PSCB_IRQ_W-1:0] = s.irq_en;
      default:            read_word = 32'h0000_0000;
    endcase
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  assign hold_s   = s_reg.sync2[PSCB_PIN_RD_HOLD];
  assign burst_s  = ~s_reg.sync2[PSCB_PIN_BURST_N];
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_comb begin
    s_next = s_reg;
    ev     = '0;

    // Pins from the fabric and the bus come from other domains
    s_next.sync1 = {pci_rst_n, status_shift_en_n, fabric_serr,
                    fabric_inta_n, read_burst_pend_n, read_start_hold};
    s_next.sync2 = s_reg.sync1;
    s_next.prev  = s_reg.sync2;

    // Forwarding to the PCI bus and the fabric
    s_next.inta_n    = s_reg.sync2[PSCB_PIN_INTA_N];
    s_next.serr_n    = ~s_reg.sync2[PSCB_PIN_SERR];
    s_next.bus_rst_n = s_reg.sync2[PSCB_PIN_BUS_RST_N];

    if (!s_reg.sync2[PSCB_PIN_INTA_N] && s_reg.prev[PSCB_PIN_INTA_N]) begin
      ev[PSCB_IRQ_INTA] = 1'b1;
    end
    if (s_reg.sync2[PSCB_PIN_SERR] && !s_reg.prev[PSCB_PIN_SERR]) begin
      ev[PSCB_IRQ_SERR] = 1'b1;
    end
    if (!s_reg.sync2[PSCB_PIN_BUS_RST_N] &&
        s_reg.prev[PSCB_PIN_BUS_RST_N]) begin
      ev[PSCB_IRQ_BUSRST] = 1'b1;
    end

    // Target read sequencing
    case (s_reg.rd_state)
      PSCB_RD_IDLE: begin
        s_next.wait_cnt = 4'h0;
        if (rd_req && s_reg.ctrl[PSCB_CTRL_RD_EN]) begin
          s_next.rd_state = PSCB_RD_HOLD;
        end
      end
      PSCB_RD_HOLD: begin
        if (!rd_req) begin
          s_next.rd_state = PSCB_RD_IDLE;
        end else if (!hold_s || rd_fifo_full) begin
          s_next.rd_state = PSCB_RD_DATA;
        end
      end
      PSCB_RD_DATA: begin
        s_next.wait_cnt = 4'h0;
        if (!rd_req) begin
          s_next.rd_state = PSCB_RD_IDLE;
        end else if (rd_fifo_empty) begin
          if (burst_s) begin
            s_next.rd_state = PSCB_RD_WAIT;
          end else begin
            s_next.rd_state = PSCB_RD_DISC;
            ev[PSCB_IRQ_DISC] = 1'b1;
          end
        end
      end
      PSCB_RD_WAIT: begin
        if (!rd_req) begin
          s_next.rd_state = PSCB_RD_IDLE;
        end else if (!rd_fifo_empty) begin
          s_next.rd_state = PSCB_RD_DATA;
        end else if (!burst_s) begin
          // Burst hint withdrawn mid-wait: stop without more waits
          s_next.rd_state   = PSCB_RD_DISC;
          ev[PSCB_IRQ_DISC] = 1'b1;
        end else if (s_reg.wait_cnt == PSCB_WAIT_LAST) begin
          s_next.rd_state      = PSCB_RD_DISC;
          ev[PSCB_IRQ_DISC]    = 1'b1;
          ev[PSCB_IRQ_WAITOUT] = 1'b1;
        end else begin
          s_next.wait_cnt = s_reg.wait_cnt + 4'h1;
        end
      end
      PSCB_RD_DISC: begin
        if (!rd_req) begin
          s_next.rd_state = PSCB_RD_IDLE;
        end
      end
      default: begin
        s_next.rd_state = PSCB_RD_IDLE;
      end
    endcase

    // Bus reset aborts any read in flight
    if (!s_reg.sync2[PSCB_PIN_BUS_RST_N]) begin
      s_next.rd_state = PSCB_RD_IDLE;
    end

    // APB: read data is captured in the setup cycle so it is a flop
    if (rd_setup) begin
      s_next.rdata = read_word(paddr, s_reg);
    end

    if (wr_acc) begin
      case (paddr)
        PSCB_ADDR_CTRL:     s_next.ctrl    = pwdata[PSCB_CTRL_W-1:0];
        PSCB_ADDR_STAT_MSK: s_next.st_mask = pwdata[PSCB_ST_W-1:0];
        PSCB_ADDR_IRQ_EN:   s_next.irq_en  = pwdata[PSCB_IRQ_W-1:0];
        default:            s_next.ctrl    = s_reg.ctrl;
      endcase
    end

    // A new event outweighs a clear written in the same cycle
    if (wr_acc && (paddr == PSCB_ADDR_IRQ_CLR)) begin
      s_next.irq_stat = (s_reg.irq_stat & ~pwdata[PSCB_IRQ_W-1:0]) | ev;
    end else begin
      s_next.irq_stat = s_reg.irq_stat | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg           <= '0;
      s_reg.sync1     <= PSCB_PIN_RST;
      s_reg.sync2     <= PSCB_PIN_RST;
      s_reg.prev      <= PSCB_PIN_RST;
      s_reg.rd_state  <= PSCB_RD_IDLE;
      s_reg.ctrl      <= PSCB_CTRL_RST;
      s_reg.st_mask   <= PSCB_STMSK_RST;
      s_reg.irq_stat  <= PSCB_IRQ_RST;
      s_reg.irq_en    <= PSCB_IRQ_RST;
      s_reg.inta_n    <= 1'b1;
      s_reg.serr_n    <= 1'b1;
      s_reg.bus_rst_n <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // Status output
  // ************************************************************
  assign stat_bus.status     = dev_status;
  assign stat_bus.mask       = s_reg.st_mask;
  assign stat_bus.shift_en_n = s_reg.sync2[PSCB_PIN_SHIFT_EN_N];

  pscb_stat_shift u_shift (
    .pclk    (pclk),
    .presetn (presetn),
    .st      (stat_bus.shifter)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit(paddr);
  assign prdata  = s_reg.rdata;
  assign irq     = |(s_reg.irq_stat & s_reg.irq_en);

  // Clock copy is a plain wire; no gating so fabric skew stays small
  assign fabric_bus_clk   = pclk;
  assign fabric_bus_rst_n = s_reg.bus_rst_n;
  assign inta_n           = s_reg.inta_n;
  assign serr_n           = s_reg.serr_n;
  assign status_out       = stat_bus.stat_out;
  // Enables only; the fabric itself keeps the idle clock low
  assign fifo_clock_a_en  = s_reg.ctrl[PSCB_CTRL_FIFO_A_EN];
  assign fifo_clock_b_en  = s_reg.ctrl[PSCB_CTRL_FIFO_B_EN] &
                            ~(s_reg.ctrl[PSCB_CTRL_DUAL_PORT] &
                              s_reg.ctrl[PSCB_CTRL_FIFO_A_EN]);

  assign trdy_n = ~((s_reg.rd_state == PSCB_RD_DATA) & ~rd_fifo_empty);
  assign stop_n = ~(s_reg.rd_state == PSCB_RD_DISC);

endmodule
`default_nettype wire

// File: tb/pci_core_sideband_control_bench.sv
// Self-checking bench for the PCI sideband control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module pci_core_sideband_control_bench
  import pscb_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pci_rst_n = 1'b1, rd_req = 1'b0;
  logic rd_fifo_full = 1'b0, rd_fifo_empty = 1'b1, errv;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
  logic [PSCB_ST_W-1:0] dev_status = 6'h00;
  logic [3:0] req = 4'h0;
  logic shift_sel = 1'b0, dt_off = 1'b0, dual = 1'b0;
  logic pready, pslverr, irq, inta_n, serr_n, trdy_n, stop_n;
  logic read_start_hold, read_burst_pend_n, fabric_inta_n, fabric_serr;
  logic status_shift_en_n, fabric_bus_clk, fabric_bus_rst_n, status_out;
  logic fifo_clock_a_en, fifo_clock_b_en;
  logic [5:0] seq;
  int bad_count = 0, n_compared = 0, n;

  always #10 pclk = ~pclk;
  pscb_top pscb_top_inst (.*);
  pscb_fabric pscb_fabric_inst (.*, .fifo_clock_a(), .fifo_clock_b());

  // ************************************************************
  // Bus and wait tasks
  // ************************************************************
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge pclk);
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // Counts edges until trdy_n (or stop_n) is seen low
  task automatic waitlo(input logic stp);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((stp ? stop_n : trdy_n) !== 1'b0 && n < 40);
  endtask
  task automatic hold_run(input logic full);
    req <= 4'h1;
    rd_fifo_empty <= 1'b0;
    tick(3);
    rd_req <= 1'b1;
    rd_fifo_full <= full;
    tick(6);
    #1 `CHK(trdy_n, !full)
    tick(1);
    req <= 4'h0;
    waitlo(1'b0);
    `CHK(n < 8, 1'b1)
    rd_req <= 1'b0;
    rd_fifo_full <= 1'b0;
    tick(2);
  endtask
  task automatic burst_run(input logic b, input int exp);
    req <= {2'b00, b, 1'b0};
    rd_fifo_empty <= 1'b0;
    tick(3);
    rd_req <= 1'b1;
    waitlo(1'b0);
    rd_fifo_empty <= 1'b1;
    waitlo(1'b1);
    `CHK(n, exp)
    rd_req <= 1'b0;
    req <= 4'h0;
    tick(2);
  endtask
  task automatic results;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    tick(2);
    presetn <= 1'b1;
    apb(1'b0, PSCB_ADDR_CTRL, 32'h0000_0000);
    `CHK(rdv, 32'h0000_0008)
    apb(1'b0, PSCB_ADDR_STAT_MSK, 32'h0000_0000);
    `CHK(rdv, 32'h0000_003F)
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK(errv, 1'b1)
    apb(1'b1, PSCB_ADDR_CTRL, 32'h0000_000F);
    #1 `CHK({fifo_clock_a_en, fifo_clock_b_en}, 2'b10)
    apb(1'b1, PSCB_ADDR_CTRL, 32'h0000_000B);
    #1 `CHK({fifo_clock_a_en, fifo_clock_b_en}, 2'b11)
    apb(1'b1, PSCB_ADDR_IRQ_EN, 32'h0000_001F);
    req <= 4'hC;
    tick(5);
    #1 `CHK({inta_n, serr_n, irq}, 3'b001)
    tick(1);
    req <= 4'h0;
    tick(6);
    #1 `CHK({inta_n, serr_n}, 2'b11)
    apb(1'b0, PSCB_ADDR_IRQ_STAT, 32'h0000_0000);
    `CHK(rdv, 32'h0000_000C)
    apb(1'b1, PSCB_ADDR_IRQ_CLR, 32'h0000_001F);
    apb(1'b1, PSCB_ADDR_IRQ_EN, 32'h0000_0000);
    req <= 4'h8;
    tick(6);
    #1 `CHK({serr_n, irq}, 2'b00)
    tick(1);
    req <= 4'h0;
    pci_rst_n <= 1'b0;
    tick(4);
    #1 `CHK(fabric_bus_rst_n, 1'b0)
    tick(1);
    pci_rst_n <= 1'b1;
    tick(4);
    #1 `CHK(fabric_bus_rst_n, 1'b1)
    apb(1'b0, PSCB_ADDR_IRQ_STAT, 32'h0000_0000);
    `CHK(rdv, 32'h0000_0014)
    hold_run(1'b0);
    hold_run(1'b1);
    burst_run(1'b0, 2);
    burst_run(1'b1, 10);
    apb(1'b0, PSCB_ADDR_IRQ_STAT, 32'h0000_0000);
    `CHK(rdv, 32'h0000_0017)
    dev_status <= 6'h25;
    tick(2);
    #1 `CHK(status_out, 1'b1)
    apb(1'b1, PSCB_ADDR_STAT_MSK, 32'h0000_0000);
    tick(2);
    #1 `CHK(status_out, 1'b0)
    apb(1'b1, PSCB_ADDR_STAT_MSK, 32'h0000_003F);
    shift_sel <= 1'b1;
    tick(8);
    for (int k = 0; k < 6; k++) begin
      @(posedge pclk);
      seq[k] = status_out;
    end
    n = 0;
    for (int k = 0; k < 6; k++)
      if (((({seq, seq} >> k) & 12'h03F) === 12'h025)) n = 1;
    `CHK(n, 1)
    shift_sel <= 1'b0;
    dev_status <= 6'h00;
    tick(4);
    #1 `CHK(status_out, 1'b0)
    @(negedge pclk);
    #1 `CHK(fabric_bus_clk, 1'b0)
    results;
  end

  initial begin
    #200000;
    bad_count++;
    results;
  end
endmodule
`default_nettype wire

// File: tb/pscb_chk.sv
// Concurrent checks on the sideband control block ports
`timescale 1ns/1ps
`default_nettype none
module pscb_chk
  import pscb_pkg::*;
(
  // Clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // Forwarded pins
  input wire logic                 pci_rst_n,
  input wire logic                 fabric_bus_rst_n,
  input wire logic                 fabric_inta_n,
  input wire logic                 inta_n,
  input wire logic                 fabric_serr,
  input wire logic                 serr_n,
  // Read engine
  input wire logic                 rd_req,
  input wire logic                 rd_fifo_full,
  input wire logic                 rd_fifo_empty,
  input wire logic                 read_start_hold,
  input wire logic                 read_burst_pend_n,
  input wire logic                 trdy_n,
  input wire logic                 stop_n,
  // Status output
  input wire logic [PSCB_ST_W-1:0] dev_status,
  input wire logic                 status_shift_en_n,
  input wire logic                 status_out
);
  // Edges since reset, so history never reaches back into reset
  logic [2:0] up_reg;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      up_reg <= 3'h0;
    else if (up_reg != 3'h7)
      up_reg <= up_reg + 3'h1;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ************************************************************
  // Read engine sequences
  // ************************************************************
  sequence held_start;
    read_start_hold[*3] ##0 $rose(rd_req);
  endsequence
  sequence drain_wait;
    (!read_burst_pend_n)[*3] ##0 (!trdy_n && rd_req)
      ##1 (rd_fifo_empty && rd_req && !read_burst_pend_n)[*8];
  endsequence

  inta_fwd_a: assert property (up_reg == 3'h7 |->
    inta_n == $past(fabric_inta_n, 3)) else $error("inta_n not forwarded");
  serr_fwd_a: assert property (up_reg == 3'h7 |->
    serr_n == !$past(fabric_serr, 3)) else $error("serr_n not forwarded");
  bus_rst_a: assert property (up_reg == 3'h7 |->
    fabric_bus_rst_n == $past(pci_rst_n, 3)) else $error("bus reset lost");
  hold_start_a: assert property (held_start ##1 (!rd_fifo_full)[*2]
    |-> trdy_n) else $error("data phase began under hold");
  disc_now_a: assert property (read_burst_pend_n[*3] ##0
    (!trdy_n && rd_req) ##1 (rd_fifo_empty && rd_req) |=> !stop_n)
    else $error("no immediate disconnect");
  wait_ok_a: assert property (drain_wait |-> stop_n && trdy_n)
    else $error("disconnect before eight wait states");
  wait_max_a: assert property (drain_wait ##1
    (rd_fifo_empty && rd_req) |=> !stop_n)
    else $error("no disconnect after eight wait states");
  or_zero_a: assert property (status_shift_en_n[*3] ##0
    (dev_status == 6'h00) |=> !status_out) else $error("status OR wrong");
  shift_per_a: assert property (
    (!status_shift_en_n && $stable(dev_status) && up_reg == 3'h7)[*8] ##1
    (!status_shift_en_n && $stable(dev_status))[*4]
    |-> status_out == $past(status_out, 6)) else $error("shift not 6 long");
endmodule
bind pscb_top pscb_chk pscb_chk_inst (.*);
`default_nettype wire

// File: tb/pscb_fabric.sv
// Fabric-side model that drives the sideband request pins
`timescale 1ns/1ps
`default_nettype none
module pscb_fabric (
  // Clock and reset from the core
  input  wire logic       fabric_bus_clk,
  input  wire logic       fabric_bus_rst_n,
  // Requests: hold, burst, interrupt, system error
  input  wire logic [3:0] req,
  input  wire logic       shift_sel,
  input  wire logic       dt_off,
  input  wire logic       dual,
  input  wire logic       fifo_clock_a_en,
  input  wire logic       fifo_clock_b_en,
  // Pins into the core
  output logic            read_start_hold,
  output logic            read_burst_pend_n,
  output logic            fabric_inta_n,
  output logic            fabric_serr,
  output logic            status_shift_en_n,
  output logic            fifo_clock_a,
  output logic            fifo_clock_b
);
  logic [3:0] act_reg;
  logic [3:0] old_reg;
  logic [3:0] act_next;
  // A one-edge request still stands for two edges
  always_comb act_next = req | (act_reg & ~old_reg);
  always_ff @(posedge fabric_bus_clk or negedge fabric_bus_rst_n)
    if (!fabric_bus_rst_n) begin
      act_reg <= 4'h0;
      old_reg <= 4'h0;
    end else begin
      act_reg <= act_next;
      old_reg <= act_reg;
    end
  assign read_start_hold   = act_reg[0];
  assign read_burst_pend_n = ~(act_reg[1] | dt_off);
  assign fabric_inta_n     = ~act_reg[2];
  assign fabric_serr       = act_reg[3];
  assign status_shift_en_n = ~shift_sel;
  assign fifo_clock_a      = fabric_bus_clk & fifo_clock_a_en;
  assign fifo_clock_b      = fabric_bus_clk & fifo_clock_b_en
                             & ~(dual & fifo_clock_a_en);
endmodule
`default_nettype wire
